// file: include/psd_pkg.sv
// Purpose: shared constants for the phased string dimming block
// Assumes: 125 MHz system clock, 10-bit pwm, 11-bit die temperature
// Notes:   register indices sit on a plain 4-bit address port
package psd_pkg;
  localparam int CLK_HZ    = 125_000_000;
  localparam int ADDR_W    = 4;
  localparam int DATA_W    = 32;
  localparam int PWM_W     = 10;
  localparam int PWM_STEPS = 1024;
  localparam int TEMP_W    = 11;
  localparam int TEMP_FRAC = 3;
  localparam int STRINGS   = 7;
  localparam int MIN_STR   = 4;

  // register indices
  localparam logic [3:0] REG_CTRL     = 4'h0;
  localparam logic [3:0] REG_CFG      = 4'h1;
  localparam logic [3:0] REG_BRT_MAIN = 4'h2;
  localparam logic [3:0] REG_BRT_SEC  = 4'h3;
  localparam logic [3:0] REG_KNEE     = 4'h4;
  localparam logic [3:0] REG_SLOPE    = 4'h5;
  localparam logic [3:0] REG_STATUS   = 4'h6;
  localparam logic [3:0] REG_TEMP_HI  = 4'h7;
  localparam logic [3:0] REG_TEMP_LO  = 4'h8;

  // configuration field positions
  localparam int CFG_W        = 11;
  localparam int CFG_DIV_LSB  = 0;
  localparam int CFG_RATE_LSB = 2;
  localparam int CFG_PS_OFF   = 5;
  localparam int CFG_MODE     = 6;
  localparam int CFG_LIM_LSB  = 7;
  localparam int CFG_STR_LSB  = 9;

  // reset values
  localparam logic [10:0] CFG_RST   = 11'h400;
  localparam logic [7:0]  BRT_RST   = 8'h00;
  localparam logic [15:0] KNEE_RST  = 16'haa55;
  localparam logic [23:0] SLOPE_RST = 24'h404040;

  // thermal derating
  localparam int LIM_BASE_C    = 100;
  localparam int LIM_STEP_C    = 10;
  localparam int DERATE_PCT    = 4;
  localparam int DERATE_SPAN_C = 100 / DERATE_PCT;
  localparam int PWM_FULL      = PWM_STEPS - 1;

  // highest shift frequency codes per mode
  localparam logic [4:0] TOP_CODE_M0 = 5'h1c;
  localparam logic [4:0] TOP_CODE_M1 = 5'h1f;

  // frequency lists in Hz
  localparam int RATE_HZ [8] = '{992, 1526, 1983, 2441, 2974, 3965,
                                 4883, 19531};
  localparam int OUT1_HZ [32] = '{229, 305, 381, 458, 534, 610, 687, 763,
                                  839, 916, 992, 1068, 1144, 1221, 1297,
                                  1373, 1450, 1526, 1602, 1678, 1755, 1831,
                                  1908, 1983, 2060, 2671, 3203, 3737, 4270,
                                  4808, 9766, 19531};

  typedef enum logic [1:0] {
    PSD_IDLE     = 2'b00,
    PSD_RUN_PS   = 2'b01,
    PSD_RUN_FLAT = 2'b11
  } psd_state_t;

  // clock cycles per pwm step at a given period rate, never below one
  function automatic logic [15:0] psd_tick_cycles(input int hz);
    int c;
    c = CLK_HZ / (hz * PWM_STEPS);
    return (c < 1) ? 16'h0001 : 16'(c);
  endfunction
endpackage

// file: logic/psd_freq_rom.sv
// Purpose: frequency code to pwm step length lookup
// Assumes: code and mode are stable while the block runs
// Notes:   read data come out of a register, one cycle of latency
module psd_freq_rom (
  input  wire logic        sys_clk_in,
  input  wire logic        rst_b_in,
  input  wire logic        mode_in,
  input  wire logic [4:0]  code_in,
  output logic      [15:0] tick_div_out
);
  import psd_pkg::*;

  // mode 0 uses the pwm rate column, mode 1 the output frequency list
  always_ff @(posedge sys_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      tick_div_out <= 16'h0001;
    end else if (mode_in) begin
      tick_div_out <= psd_tick_cycles(OUT1_HZ[code_in]);
    end else begin
      tick_div_out <= psd_tick_cycles(RATE_HZ[code_in[4:2]]);
    end
  end
endmodule

// file: logic/psd_phase_pwm.sv
// Purpose: rotating phase shifted pwm for the led strings, with derating
// Assumes: die temperature arrives unsynchronised, 8.3 fixed point degC
// Notes:   configuration is frozen while the run bit is set
//
// Implementation choices: strobed register access and the address map.
module psd_phase_pwm (
  input  wire logic                        sys_clk_in,
  input  wire logic                        rst_b_in,
  input  wire logic [psd_pkg::ADDR_W-1:0]  addr_in,
  input  wire logic [psd_pkg::DATA_W-1:0]  wr_data_in,
  input  wire logic                        wr_stb_in,
  input  wire logic                        rd_stb_in,
  input  wire logic [psd_pkg::TEMP_W-1:0]  die_temp_in,
  output logic      [psd_pkg::DATA_W-1:0]  rd_data_out,
  output logic      [psd_pkg::STRINGS-1:0] string_on_out,
  output logic                             boost_const_out
);
  import psd_pkg::*;

  // 3-segment curve, slopes in 1/16 pwm step per brightness step
  function automatic logic [9:0] curve10(input logic [7:0] b,
                                         input logic [15:0] kn,
                                         input logic [23:0] sl);
    logic [17:0] y1;
    logic [17:0] y2;
    logic [17:0] y;
    y1 = 18'(kn[7:0] * sl[7:0]);
    y2 = y1 + 18'((kn[15:8] - kn[7:0]) * sl[15:8]);
    if (b < kn[7:0]) begin
      y = 18'(b * sl[7:0]);
    end else if (b < kn[15:8]) begin
      y = y1 + 18'((b - kn[7:0]) * sl[15:8]);
    end else begin
      y = y2 + 18'((b - kn[15:8]) * sl[23:16]);
    end
    y = y >> 4;
    return (y > 18'(PWM_FULL)) ? 10'(PWM_FULL) : y[9:0];
  endfunction

  // subtract 4% of full scale per degree above the limit, floor at zero
  function automatic logic [9:0] derate(input logic [9:0] pwm,
                                        input logic [7:0] ex);
    logic [17:0] red;
    red = (ex >= 8'(DERATE_SPAN_C)) ? 18'(PWM_FULL)
        : 18'((ex * PWM_FULL) / DERATE_SPAN_C);
    return (18'(pwm) > red) ? 10'(18'(pwm) - red) : 10'h000;
  endfunction

  logic                run;
  logic [CFG_W-1:0]    cfg;
  logic [CFG_W-1:0]    act_cfg;
  logic [7:0]          brt_main;
  logic [7:0]          brt_sec;
  logic [15:0]         knee;
  logic [23:0]         slope;
  logic [TEMP_W-1:0]   t_s1;
  logic [TEMP_W-1:0]   t_s2;
  logic [TEMP_W-1:0]   t_s3;
  logic [TEMP_W-1:0]   temp_q;
  logic [TEMP_FRAC-1:0] temp_lo_shadow;
  psd_state_t          state;
  psd_state_t          next_state;
  logic [15:0]         rom_tick;
  logic [15:0]         tick_lim_q;
  logic [15:0]         cnt_q;
  logic [9:0]          phase_q;
  logic [2:0]          sub_q;
  logic [2:0]          pos_q;
  logic [9:0]          pwm_main_q;
  logic [9:0]          pwm_sec_q;
  logic [9:0]          duty_q;
  logic [9:0]          sec_duty_q;
  logic [2:0]          k_q;
  logic [9:0]          r_q;
  logic [STRINGS-1:0]  next_on;

  // decoded active configuration
  logic [1:0] div_sel;
  logic [4:0] code;
  logic       ps_off;
  logic       mode;
  logic [1:0] lim_sel;
  logic [2:0] n_str;
  logic [7:0] limit_deg;
  logic [7:0] temp_deg;
  logic [7:0] excess;
  logic [2:0] sub_max;
  logic       tick;
  logic       wrap;
  logic       shift_evt;
  logic       top_code;
  logic [12:0] dn;
  logic [15:0] tick_calc;

  assign div_sel   = act_cfg[CFG_DIV_LSB +: 2];
  assign code      = act_cfg[CFG_DIV_LSB +: 5];
  assign ps_off    = act_cfg[CFG_PS_OFF];
  assign mode      = act_cfg[CFG_MODE];
  assign lim_sel   = act_cfg[CFG_LIM_LSB +: 2];
  assign n_str     = 3'(MIN_STR) + {1'b0, act_cfg[CFG_STR_LSB +: 2]};
  assign limit_deg = 8'(LIM_BASE_C) + 8'(LIM_STEP_C) * {6'h00, lim_sel};
  assign temp_deg  = temp_q[TEMP_W-1:TEMP_FRAC];
  assign excess    = (temp_deg > limit_deg) ? temp_deg - limit_deg : 8'h00;
  // mode 1 shifts once per pwm period, so no sub-division there
  assign sub_max   = mode ? 3'h0 : 3'((4'h1 << div_sel) - 4'h1);
  assign tick      = (cnt_q == tick_lim_q - 16'h0001);
  assign wrap      = tick && (phase_q == 10'(PWM_FULL));
  assign shift_evt = wrap && (sub_q == sub_max) && (state == PSD_RUN_PS);
  assign top_code  = mode ? (code == TOP_CODE_M1) : (code == TOP_CODE_M0);
  assign dn        = 13'(pwm_main_q * n_str); // k and r match the new duty

  // register writes; only the config word waits for a stop to reach the pwm logic
  always_ff @(posedge sys_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      run      <= 1'b0;
      cfg      <= CFG_RST;
      brt_main <= BRT_RST;
      brt_sec  <= BRT_RST;
      knee     <= KNEE_RST;
      slope    <= SLOPE_RST;
    end else if (wr_stb_in) begin
      case (addr_in)
        REG_CTRL:     run      <= wr_data_in[0];
        REG_CFG:      cfg      <= wr_data_in[CFG_W-1:0];
        REG_BRT_MAIN: brt_main <= wr_data_in[7:0];
        REG_BRT_SEC:  brt_sec  <= wr_data_in[7:0];
        REG_KNEE:     knee     <= wr_data_in[15:0];
        REG_SLOPE:    slope    <= wr_data_in[23:0];
        default:      ;
      endcase
    end
  end

  // load at enable: a running block never sees a half-changed config
  always_ff @(posedge sys_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      act_cfg <= CFG_RST;
    end else if (!run) begin
      act_cfg <= cfg;
    end
  end

  // three-stage sync; a word is taken once the last two stages agree
  always_ff @(posedge sys_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      t_s1   <= '0;
      t_s2   <= '0;
      t_s3   <= '0;
      temp_q <= '0;
    end else begin
      t_s1 <= die_temp_in;
      t_s2 <= t_s1;
      t_s3 <= t_s2;
      if (t_s2 == t_s3) begin
        temp_q <= t_s3;
      end
    end
  end

  // register reads; data stand only in the cycle after the strobe
  always_ff @(posedge sys_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      rd_data_out    <= '0;
      temp_lo_shadow <= '0;
    end else begin
      rd_data_out <= '0;
      if (rd_stb_in) begin
        case (addr_in)
          REG_CTRL:     rd_data_out <= 32'(run);
          REG_CFG:      rd_data_out <= 32'(cfg);
          REG_BRT_MAIN: rd_data_out <= 32'(brt_main);
          REG_BRT_SEC:  rd_data_out <= 32'(brt_sec);
          REG_KNEE:     rd_data_out <= 32'(knee);
          REG_SLOPE:    rd_data_out <= 32'(slope);
          REG_STATUS:   rd_data_out <= {6'h00, pwm_main_q, 7'h00,
                                        k_q, pos_q, boost_const_out,
                                        (excess != 8'h00), state[0]};
          REG_TEMP_HI: begin
            rd_data_out    <= 32'(temp_q[TEMP_W-1:TEMP_FRAC]);
            temp_lo_shadow <= temp_q[TEMP_FRAC-1:0];
          end
          REG_TEMP_LO:  rd_data_out <= 32'(temp_lo_shadow);
          default:      rd_data_out <= '0;
        endcase
      end
    end
  end

  // run state; the off bit picks plain simultaneous pwm
  always_comb begin
    case (state)
      PSD_IDLE:     next_state = !run ? PSD_IDLE
                               : ps_off ? PSD_RUN_FLAT : PSD_RUN_PS;
      PSD_RUN_PS:   next_state = run ? PSD_RUN_PS : PSD_IDLE;
      PSD_RUN_FLAT: next_state = run ? PSD_RUN_FLAT : PSD_IDLE;
      default:      next_state = PSD_IDLE;
    endcase
  end

  always_ff @(posedge sys_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      state <= PSD_IDLE;
    end else begin
      state <= next_state;
    end
  end

  psd_freq_rom u_rom (
    .sys_clk_in   (sys_clk_in),
    .rst_b_in     (rst_b_in),
    .mode_in      (mode),
    .code_in      (code),
    .tick_div_out (rom_tick)
  );

  // mode 1 shifting runs one pwm period per shift, N times the string rate
  assign tick_calc = (mode && !ps_off) ? rom_tick / 16'(n_str) : rom_tick;

  always_ff @(posedge sys_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      tick_lim_q <= 16'h0001;
    end else if (state == PSD_IDLE) begin
      tick_lim_q <= (tick_calc == 16'h0000) ? 16'h0001 : tick_calc;
    end
  end

  // step divider and 10-bit pwm phase
  always_ff @(posedge sys_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      cnt_q   <= '0;
      phase_q <= '0;
    end else if (state == PSD_IDLE) begin
      cnt_q   <= '0;
      phase_q <= '0;
    end else if (tick) begin
      cnt_q   <= '0;
      phase_q <= phase_q + 10'h001;
    end else begin
      cnt_q <= cnt_q + 16'h0001;
    end
  end

  // period count within a shift period, then rotate one place
  always_ff @(posedge sys_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      sub_q <= '0;
      pos_q <= '0;
    end else if (state == PSD_IDLE) begin
      sub_q <= '0;
      pos_q <= '0;
    end else if (wrap) begin
      sub_q <= (sub_q == sub_max) ? 3'h0 : sub_q + 3'h1;
      if (shift_evt) begin
        pos_q <= (pos_q == n_str - 3'h1) ? 3'h0 : pos_q + 3'h1;
      end
    end
  end

  // brightness curve and derating, recomputed every cycle
  always_ff @(posedge sys_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      pwm_main_q <= '0;
      pwm_sec_q  <= '0;
    end else begin
      pwm_main_q <= derate(curve10(brt_main, knee, slope), excess);
      pwm_sec_q  <= derate({brt_sec, brt_sec[7:6]}, excess);
    end
  end

  // duties change only at a period boundary or while idle, to avoid runt pulses
  always_ff @(posedge sys_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      duty_q     <= '0;
      sec_duty_q <= '0;
      k_q        <= '0;
      r_q        <= '0;
    end else if (state == PSD_IDLE || wrap) begin
      duty_q     <= pwm_main_q;
      sec_duty_q <= pwm_sec_q;
      k_q        <= dn[12:10];
      r_q        <= dn[9:0];
    end
  end

  // per string decision: full, partial or off by rotated position
  always_comb begin
    logic [2:0] j;
    next_on = '0;
    j       = 3'h0;
    for (int i = 0; i < STRINGS; i++) begin
      j = (3'(i) >= pos_q) ? 3'(i) - pos_q : 3'(i) + n_str - pos_q;
      if (state == PSD_IDLE) begin
        next_on[i] = 1'b0;
      end else if (3'(i) < n_str) begin
        if (state == PSD_RUN_FLAT) begin
          next_on[i] = phase_q < duty_q;
        end else begin
          next_on[i] = (j < k_q) || (j == k_q && phase_q < r_q);
        end
      end else if (i == STRINGS - 1) begin
        next_on[i] = phase_q < sec_duty_q;
      end
    end
  end

  always_ff @(posedge sys_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      string_on_out   <= '0;
      boost_const_out <= 1'b0;
    end else begin
      string_on_out   <= next_on;
      boost_const_out <= (state == PSD_RUN_PS) && top_code;
    end
  end

  // checks on the running behaviour
  default clocking cb @(posedge sys_clk_in); endclocking
  default disable iff (!rst_b_in);

  logic [STRINGS-1:0] main_mask;
  assign main_mask = 7'((8'h01 << n_str) - 8'h01);

  property p_share;
    (state == PSD_RUN_PS) |=>
      $countones(string_on_out & main_mask) <= $past(k_q) + 3'h1;
  endproperty
  a_share: assert property (p_share) else $error("too many strings on");

  property p_rot;
    (shift_evt && pos_q != n_str - 3'h1) |=> pos_q == $past(pos_q) + 3'h1;
  endproperty
  a_rot: assert property (p_rot) else $error("rotation did not advance");

  property p_sec;
    (state != PSD_IDLE && n_str != 3'(STRINGS)) |=>
      string_on_out[STRINGS-1] == $past(phase_q < sec_duty_q);
  endproperty
  a_sec: assert property (p_sec) else $error("secondary not plain pwm");

  property p_div;
    shift_evt |-> (mode || sub_q == 3'((4'h1 << div_sel) - 4'h1));
  endproperty
  a_div: assert property (p_div) else $error("shift rate divider wrong");

  property p_boost;
    ##1 boost_const_out == $past(state == PSD_RUN_PS && top_code);
  endproperty
  a_boost: assert property (p_boost) else $error("boost hold wrong");

  property p_flat;
    (state == PSD_RUN_FLAT) |=>
      (string_on_out[3:0] == {4{string_on_out[0]}});
  endproperty
  a_flat: assert property (p_flat) else $error("flat pwm not in step");

  property p_hot;
    (excess >= 8'(DERATE_SPAN_C)) [*2] |=> pwm_main_q == 10'h000;
  endproperty
  a_hot: assert property (p_hot) else $error("derating not to zero");

  property p_clamp;
    ##1 pwm_main_q <= $past(curve10(brt_main, knee, slope));
  endproperty
  a_clamp: assert property (p_clamp) else $error("derated above curve");

  property p_latch;
    (rd_stb_in && addr_in == REG_TEMP_HI) |=>
      temp_lo_shadow == $past(temp_q[TEMP_FRAC-1:0]);
  endproperty
  a_latch: assert property (p_latch) else $error("temp low not latched");

  c_shift: cover property (shift_evt);
  c_hot:   cover property (excess != 8'h00 && state != PSD_IDLE);
  c_boost: cover property (boost_const_out);
  c_temp:  cover property (rd_stb_in && addr_in == REG_TEMP_HI ##1
                           rd_stb_in && addr_in == REG_TEMP_LO);
endmodule

// file: test/psd_led_sink.sv
// Purpose: behavioural model of the led string sinks and the boost supply
// Assumes: a string sinks current whenever its on bit is high
// Notes:   boost level is an abstract step count, not volts
module psd_led_sink (
  input  wire logic                       sys_clk_in,
  input  wire logic                       rst_b_in,
  input  wire logic [psd_pkg::STRINGS-1:0] string_on_in,
  input  wire logic [2:0]                 main_n_in,
  input  wire logic                       boost_const_in,
  input  wire logic                       clear_in,
  output logic      [3:0]                 max_main_out,
  output logic                            sec_seen_out,
  output logic      [3:0]                 boost_level_out
);
  import psd_pkg::*;

  logic [3:0]         on_now;
  logic [STRINGS-1:0] main_mask;

  // only the main group loads the boost together
  assign main_mask = STRINGS'((8'h01 << main_n_in) - 8'h01);

  // count main strings sinking current in this cycle
  always_comb begin
    on_now = 4'h0;
    for (int i = 0; i < STRINGS; i++)
      on_now = on_now + 4'(string_on_in[i] & main_mask[i]);
  end

  // worst simultaneous load since the last clear
  always_ff @(posedge sys_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      max_main_out <= 4'h0;
      sec_seen_out <= 1'b0;
    end else if (clear_in) begin
      max_main_out <= 4'h0;
      sec_seen_out <= 1'b0;
    end else begin
      if (on_now > max_main_out)
        max_main_out <= on_now;
      if (string_on_in[STRINGS-1] && main_n_in < 3'(STRINGS))
        sec_seen_out <= 1'b1;
    end
  end

  // the supply adapts per step unless told to hold for the worst string
  always_ff @(posedge sys_clk_in or negedge rst_b_in) begin
    if (!rst_b_in)
      boost_level_out <= 4'h0;
    else
      boost_level_out <= boost_const_in ? 4'hf : on_now;
  end
endmodule

// file: test/phase_shift_led_pwm_bench.sv
// Purpose: self-checking bench for the phased string dimming block
// Assumes: register bus with read data one cycle after the strobe
// Notes:   derating sets the duty to exact values, so the curve is clamped
module phase_shift_led_pwm_bench;
  timeunit 1ns;
  timeprecision 1ps;
  import psd_pkg::*;

  logic                sys_clk_in = 1'b0;
  logic                rst_b_in = 1'b0;
  logic [ADDR_W-1:0]   addr_in = 4'h0;
  logic [DATA_W-1:0]   wr_data_in = 32'h0;
  logic                wr_stb_in = 1'b0;
  logic                rd_stb_in = 1'b0;
  logic [TEMP_W-1:0]   die_temp_in = 11'h000;
  logic                clr = 1'b0;
  logic [DATA_W-1:0]   rd_data_out;
  logic [STRINGS-1:0]  string_on_out;
  logic                boost_const_out;
  logic [3:0]          max_main;
  logic                sec_seen;
  logic [31:0]         rdv;
  int                  mismatches = 0;
  int                  checked = 0;
  int                  cyc = 0;

  // 125 MHz clock and a free cycle count for period measurement
  always #4 sys_clk_in = ~sys_clk_in;
  always @(posedge sys_clk_in) cyc <= cyc + 1;

  psd_phase_pwm dut (
    .sys_clk_in      (sys_clk_in),
    .rst_b_in        (rst_b_in),
    .addr_in         (addr_in),
    .wr_data_in      (wr_data_in),
    .wr_stb_in       (wr_stb_in),
    .rd_stb_in       (rd_stb_in),
    .die_temp_in     (die_temp_in),
    .rd_data_out     (rd_data_out),
    .string_on_out   (string_on_out),
    .boost_const_out (boost_const_out)
  );

  psd_led_sink sink (
    .sys_clk_in      (sys_clk_in),
    .rst_b_in        (rst_b_in),
    .string_on_in    (string_on_out),
    .main_n_in       (3'd6),
    .boost_const_in  (boost_const_out),
    .clear_in        (clr),
    .max_main_out    (max_main),
    .sec_seen_out    (sec_seen),
    .boost_level_out ()
  );

  task automatic give_verdict();
    $display("checks %0d, mismatches %0d", checked, mismatches);
    if (mismatches == 0 && checked > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      mismatches++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // bus cycles: strobes last one cycle, read data taken the cycle after
  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    @(posedge sys_clk_in);
    addr_in <= a;
    wr_data_in <= d;
    wr_stb_in <= 1'b1;
    @(posedge sys_clk_in);
    wr_stb_in <= 1'b0;
  endtask

  task automatic rd(input logic [3:0] a, output logic [31:0] d);
    @(posedge sys_clk_in);
    addr_in <= a;
    rd_stb_in <= 1'b1;
    @(posedge sys_clk_in);
    rd_stb_in <= 1'b0;
    #1;
    d = rd_data_out;
  endtask

  task automatic rdchk(input logic [3:0] a, input logic [31:0] e);
    rd(a, rdv);
    chk(rdv, e);
  endtask

  // status fields may lag by a pwm period, so poll under a bound
  task automatic poll(input logic [31:0] m, input logic [31:0] e);
    for (int i = 0; i < 4000; i++) begin
      rd(REG_STATUS, rdv);
      if ((rdv & m) === e)
        break;
    end
    chk(rdv & m, e);
  endtask

  // temperature in eighths of a degree, past the three-flop synchroniser
  task automatic settemp(input int t8);
    @(posedge sys_clk_in);
    die_temp_in <= 11'(t8);
    repeat (8) @(posedge sys_clk_in);
  endtask

  function automatic logic [31:0] cfgv(input logic [4:0] code,
      input logic off, input logic mode, input logic [1:0] lim,
      input logic [1:0] nsel);
    return {21'h0, nsel, lim, mode, off, code};
  endfunction

  // config only loads while stopped
  task automatic start(input logic [31:0] c);
    wr(REG_CTRL, 32'h0);
    wr(REG_CFG, c);
    wr(REG_CTRL, 32'h1);
    repeat (8) @(posedge sys_clk_in);
  endtask

  task automatic next_pos(input logic [2:0] p, output logic [2:0] q);
    q = p;
    for (int i = 0; i < 8000 && q === p; i++) begin
      rd(REG_STATUS, rdv);
      q = rdv[5:3];
    end
  endtask

  // one step of rotation, and its spacing within the polling jitter
  task automatic shift_chk(input int exp_cyc);
    logic [2:0] p;
    logic [2:0] q;
    logic [2:0] s;
    int         c;
    rd(REG_STATUS, rdv);
    p = rdv[5:3];
    next_pos(p, q);
    c = cyc;
    next_pos(q, s);
    c = cyc - c;
    if (c >= exp_cyc - 2 && c <= exp_cyc + 2)
      c = exp_cyc;
    chk(32'(s), 32'((q + 1) % 6));
    chk(32'(c), 32'(exp_cyc));
  endtask

  initial begin
    int lim;
    repeat (6) @(posedge sys_clk_in);
    rst_b_in <= 1'b1;
    rdchk(REG_CTRL, 32'h0);
    rdchk(REG_CFG, 32'h400);
    rdchk(REG_KNEE, 32'haa55);
    rdchk(REG_SLOPE, 32'h404040);
    rdchk(4'hf, 32'h0);
    // low bits are held from the high read even if the sensor moves
    wr(REG_TEMP_HI, 32'hff);
    settemp(32'h4d5);
    rdchk(REG_TEMP_HI, 32'h9a);
    settemp(32'h4d2);
    rdchk(REG_TEMP_LO, 32'h5);
    rdchk(REG_TEMP_HI, 32'h9a);
    rdchk(REG_TEMP_LO, 32'h2);
    // steep slopes clamp the curve at full scale for brightness 255
    wr(REG_SLOPE, 32'hffffff);
    wr(REG_BRT_MAIN, 32'hff);
    wr(REG_BRT_SEC, 32'hff);
    // each limit select; alternate excess so a stale value never matches
    for (int s = 0; s < 4; s++) begin
      lim = 100 + 10 * s;
      start(cfgv(5'h1c, 1'b0, 1'b0, 2'(s), 2'd2));
      settemp((lim + ((s % 2) ? 5 : 13)) * 8);
      poll(32'h3ff0000, (s % 2) ? 32'd819 << 16 : 32'd492 << 16);
    end
    settemp(130 * 8);
    poll(32'h3ff0000, 32'd1023 << 16);
    settemp(155 * 8);
    poll(32'h3ff0000, 32'd0);
    settemp(200 * 8);
    poll(32'h3ff0000, 32'd0);
    settemp(129 * 8);
    poll(32'h3ff0000, 32'd1023 << 16);
    // duty 492 over six strings: two full, one partial
    start(cfgv(5'h1c, 1'b0, 1'b0, 2'd0, 2'd2));
    settemp(113 * 8);
    poll(32'h1c0, 32'd2 << 6);
    @(posedge sys_clk_in);
    clr <= 1'b1;
    @(posedge sys_clk_in);
    clr <= 1'b0;
    repeat (13000) @(posedge sys_clk_in);
    chk(32'(max_main), 32'd3);
    chk(32'(sec_seen), 32'd1);
    chk(32'(boost_const_out), 32'd1);
    shift_chk(6144);
    // shifting off: all main strings together
    start(cfgv(5'h1c, 1'b1, 1'b0, 2'd0, 2'd2));
    @(posedge sys_clk_in);
    clr <= 1'b1;
    @(posedge sys_clk_in);
    clr <= 1'b0;
    repeat (13000) @(posedge sys_clk_in);
    chk(32'(max_main), 32'd6);
    chk(32'(boost_const_out), 32'd0);
    // halved shift rate, then the second frequency set
    start(cfgv(5'h1d, 1'b0, 1'b0, 2'd0, 2'd2));
    chk(32'(boost_const_out), 32'd0);
    shift_chk(12288);
    start(cfgv(5'h1f, 1'b0, 1'b1, 2'd0, 2'd2));
    chk(32'(boost_const_out), 32'd1);
    shift_chk(1024);
    // default curve, third segment: brightness 192 maps to 768 when cool
    wr(REG_SLOPE, 32'h404040);
    wr(REG_BRT_MAIN, 32'hc0);
    settemp(50 * 8);
    poll(32'h3ff0000, 32'd768 << 16);
    give_verdict();
  end

  // the tests need about 72k cycles; a hang is cut below 100k
  initial begin
    repeat (95000) @(posedge sys_clk_in);
    mismatches++;
    give_verdict();
  end
endmodule
